// file: design/analog_freq_input_select.sv
// Analog frequency-command selector with APB register access.
// Assumes samples come from a digitiser on clk; pins are asynchronous.
`timescale 1ns/1ns
module analog_freq_input_select (
    input  wire logic        clk,          // 20 MHz clock
    input  wire logic        arst_n,       // Async reset, active low
    input  wire logic        psel,         // APB select
    input  wire logic        penable,      // APB enable
    input  wire logic        pwrite,       // APB write
    input  wire logic [7:0]  paddr,        // APB byte address
    input  wire logic [31:0] pwdata,       // APB write data
    output logic      [31:0] prdata,       // APB read data
    output logic             pready,       // APB ready
    output logic             pslverr,      // APB error
    input  wire logic [11:0] ch1_sample,   // First channel digitised value
    input  wire logic [11:0] ch2_sample,   // Second channel digitised value
    input  wire logic        ch2_enable_pin, // Dedicated enable pin
    input  wire logic [4:0]  term_pins,    // General input terminals
    input  wire logic        volt_switch,  // Input-type switch, high at V
    output logic      [15:0] freq_cmd,     // Frequency command magnitude
    output logic             reverse_cmd,  // High for reverse rotation
    output logic             cmd_valid     // A channel is the source
);
    // ====================================================================
    // Pin synchronisers
    // Pins are asynchronous; only the second flop feeds logic
    logic [6:0] sync1_ff;
    logic [6:0] sync2_ff;
    logic [6:0] nxt_sync1;
    logic [6:0] nxt_sync2;

    always_comb begin
        nxt_sync1 = {volt_switch, ch2_enable_pin, term_pins};
        nxt_sync2 = sync1_ff;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_ff <= 7'h00;
            sync2_ff <= 7'h00;
        end else begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
        end
    end

    // ====================================================================
    // Register file
    logic [7:0]  sel_ff,   nxt_sel;
    logic [7:0]  type_ff,  nxt_type;
    logic [7:0]  vis_ff,   nxt_vis;
    logic [15:0] therm_ff, nxt_therm;
    logic [7:0]  fn_ff  [freq_sel_pkg::NUM_TERM];
    logic [7:0]  nxt_fn [freq_sel_pkg::NUM_TERM];
    logic [15:0] g1f_ff,   nxt_g1f;
    logic [15:0] g2f_ff,   nxt_g2f;
    logic [11:0] b1_ff,    nxt_b1;
    logic [11:0] p1_ff,    nxt_p1;
    logic [11:0] b2_ff,    nxt_b2;
    logic [11:0] p2_ff,    nxt_p2;
    logic [31:0] prdata_ff, nxt_prdata;
    logic        pready_ff, nxt_pready;
    logic        pslverr_ff, nxt_pslverr;

    logic [31:0] status;
    logic        setup;
    logic        commit;
    logic        hit;
    logic        bad;
    logic [31:0] rd;
    logic [7:0]  wb;

    assign setup  = psel && !penable;
    assign commit = psel && penable && pready_ff && pwrite && !pslverr_ff;
    assign wb     = pwdata[7:0];

    // Decode and legality of the access, judged in the setup cycle
    always_comb begin
        hit = 1'b1;
        bad = 1'b0;
        rd  = 32'h0;
        case (paddr)
            freq_sel_pkg::OFS_ANALOG_SEL: begin
                rd = {24'h0, sel_ff};
                if (pwrite) begin
                    bad = (vis_ff != 8'h00) ||
                          !(wb == freq_sel_pkg::SEL_10V ||
                            wb == freq_sel_pkg::SEL_5V ||
                            wb == freq_sel_pkg::SEL_10V_REV ||
                            wb == freq_sel_pkg::SEL_5V_REV);
                end
            end

            freq_sel_pkg::OFS_CH2_TYPE: begin
                rd = {24'h0, type_ff};
                if (pwrite) begin
                    bad = (vis_ff != 8'h00) || (wb > freq_sel_pkg::TYPE_10V);
                end
            end

            freq_sel_pkg::OFS_EXT_VIS:   rd = {24'h0, vis_ff};
            freq_sel_pkg::OFS_THERM:     rd = {16'h0, therm_ff};
            freq_sel_pkg::OFS_CH1_GFREQ: rd = {16'h0, g1f_ff};
            freq_sel_pkg::OFS_CH2_GFREQ: rd = {16'h0, g2f_ff};
            freq_sel_pkg::OFS_CH1_BIAS:  rd = {20'h0, b1_ff};
            freq_sel_pkg::OFS_CH1_GAIN:  rd = {20'h0, p1_ff};
            freq_sel_pkg::OFS_CH2_BIAS:  rd = {20'h0, b2_ff};
            freq_sel_pkg::OFS_CH2_GAIN:  rd = {20'h0, p2_ff};

            freq_sel_pkg::OFS_STATUS: begin
                rd  = status;
                bad = pwrite;
            end

            default: begin
                hit = 1'b0;
                for (int i = 0; i < freq_sel_pkg::NUM_TERM; i++) begin
                    if (paddr == freq_sel_pkg::OFS_TERM_FN0 + 8'(4 * i)) begin
                        hit = 1'b1;
                        rd  = {24'h0, fn_ff[i]};
                    end
                end
                bad = !hit;
            end
        endcase
    end

    always_comb begin
        nxt_sel     = sel_ff;
        nxt_type    = type_ff;
        nxt_vis     = vis_ff;
        nxt_therm   = therm_ff;
        nxt_fn      = fn_ff;
        nxt_g1f     = g1f_ff;
        nxt_g2f     = g2f_ff;
        nxt_b1      = b1_ff;
        nxt_p1      = p1_ff;
        nxt_b2      = b2_ff;
        nxt_p2      = p2_ff;

        nxt_pready  = setup;
        nxt_pslverr = setup ? bad : 1'b0;
        nxt_prdata  = (setup && !pwrite) ? rd : 32'h0;

        // A write lands only at the ready edge and never when refused
        if (commit) begin
            case (paddr)
                freq_sel_pkg::OFS_ANALOG_SEL: nxt_sel   = wb;
                freq_sel_pkg::OFS_CH2_TYPE:   nxt_type  = wb;
                freq_sel_pkg::OFS_EXT_VIS:    nxt_vis   = wb;
                freq_sel_pkg::OFS_THERM:      nxt_therm = pwdata[15:0];
                freq_sel_pkg::OFS_CH1_GFREQ:  nxt_g1f   = pwdata[15:0];
                freq_sel_pkg::OFS_CH2_GFREQ:  nxt_g2f   = pwdata[15:0];
                freq_sel_pkg::OFS_CH1_BIAS:   nxt_b1    = pwdata[11:0];
                freq_sel_pkg::OFS_CH1_GAIN:   nxt_p1    = pwdata[11:0];
                freq_sel_pkg::OFS_CH2_BIAS:   nxt_b2    = pwdata[11:0];
                freq_sel_pkg::OFS_CH2_GAIN:   nxt_p2    = pwdata[11:0];
                default: begin
                    for (int i = 0; i < freq_sel_pkg::NUM_TERM; i++) begin
                        if (paddr == freq_sel_pkg::OFS_TERM_FN0 + 8'(4 * i)) begin
                            nxt_fn[i] = wb;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sel_ff     <= freq_sel_pkg::SEL_5V;
            type_ff    <= freq_sel_pkg::TYPE_CURRENT;
            vis_ff     <= freq_sel_pkg::EXT_VIS_RST;
            therm_ff   <= freq_sel_pkg::THERM_OFF;
            for (int i = 0; i < freq_sel_pkg::NUM_TERM; i++) begin
                fn_ff[i] <= freq_sel_pkg::TERM_FN_RST;
            end
            g1f_ff     <= freq_sel_pkg::GFREQ_RST;
            g2f_ff     <= freq_sel_pkg::GFREQ_RST;
            b1_ff      <= freq_sel_pkg::CH1_BIAS_RST;
            p1_ff      <= freq_sel_pkg::GAIN_PT_RST;
            b2_ff      <= freq_sel_pkg::CH2_BIAS_RST;
            p2_ff      <= freq_sel_pkg::GAIN_PT_RST;

            prdata_ff  <= 32'h0;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            sel_ff     <= nxt_sel;
            type_ff    <= nxt_type;
            vis_ff     <= nxt_vis;
            therm_ff   <= nxt_therm;
            fn_ff      <= nxt_fn;
            g1f_ff     <= nxt_g1f;
            g2f_ff     <= nxt_g2f;
            b1_ff      <= nxt_b1;
            p1_ff      <= nxt_p1;
            b2_ff      <= nxt_b2;
            p2_ff      <= nxt_p2;

            prdata_ff  <= nxt_prdata;
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;

    // ====================================================================
    // Channel selection and conversion
    function automatic logic [11:0] half_scale(input logic [11:0] x);
        // 0-5 V fills only the lower half of the converter span
        half_scale = x[11] ? freq_sel_pkg::ADC_FULL : {x[10:0], 1'b0};
    endfunction : half_scale

    // Below the bias point the channel reverses when allowed, else stays at zero
    function automatic logic [16:0] interp(
        input logic [11:0] x,
        input logic [11:0] bp,
        input logic [11:0] gp,
        input logic [15:0] gf,
        input logic        rev_ok
    );
        logic [11:0] den;
        logic [11:0] dx;
        logic [27:0] q;
        logic        neg;

        den = (gp > bp) ? (gp - bp) : 12'h001;
        neg = x < bp;
        dx  = neg ? (bp - x) : (x - bp);
        q   = (28'(dx) * 28'(gf)) / 28'(den);

        if (q > 28'(gf)) begin
            q = 28'(gf);
        end
        if (neg && !rev_ok) begin
            interp = 17'h0;
        end else begin
            interp = {neg, q[15:0]};
        end
    endfunction : interp

    logic        fn_hit;
    logic        fn_en;
    logic        ch2_en;
    logic        rev_ok;
    logic        ch1_ok;
    logic        mismatch;

    logic [11:0] x1;
    logic [11:0] x2;
    logic [16:0] r1;
    logic [16:0] r2;

    logic [15:0] nxt_freq;
    logic        nxt_rev;
    logic        nxt_valid;
    logic        nxt_src2;

    logic [15:0] freq_ff;
    logic        rev_ff;
    logic        valid_ff;
    logic        src2_ff;
    logic        mism_ff;

    always_comb begin
        fn_hit = 1'b0;
        fn_en  = 1'b0;
        for (int i = 0; i < freq_sel_pkg::NUM_TERM; i++) begin
            if (fn_ff[i] == freq_sel_pkg::FN_CH2_ENABLE) begin
                fn_hit = 1'b1;
                fn_en  = fn_en | sync2_ff[i];
            end
        end
    end

    always_comb begin
        ch2_en   = fn_hit ? fn_en : sync2_ff[5];
        rev_ok   = (sel_ff == freq_sel_pkg::SEL_10V_REV) ||
                   (sel_ff == freq_sel_pkg::SEL_5V_REV);
        ch1_ok   = (therm_ff == freq_sel_pkg::THERM_OFF);
        // Switch and type must agree, otherwise the channel is held off
        mismatch = (type_ff == freq_sel_pkg::TYPE_CURRENT) == sync2_ff[6];
        x1 = (sel_ff == freq_sel_pkg::SEL_5V || sel_ff == freq_sel_pkg::SEL_5V_REV)
             ? half_scale(ch1_sample) : ch1_sample;
        x2 = (type_ff == freq_sel_pkg::TYPE_5V) ? half_scale(ch2_sample)
                                                : ch2_sample;

        r1 = interp(x1, b1_ff, p1_ff, g1f_ff, rev_ok);
        r2 = interp(x2, b2_ff, p2_ff, g2f_ff, rev_ok);

        nxt_src2  = ch2_en;
        nxt_valid = 1'b0;
        nxt_freq  = 16'h0;
        nxt_rev   = 1'b0;

        if (ch2_en) begin
            if (!mismatch) begin
                nxt_valid = 1'b1;
                nxt_freq  = r2[15:0];
                nxt_rev   = r2[16];
            end
        end else if (ch1_ok) begin
            nxt_valid = 1'b1;
            nxt_freq  = r1[15:0];
            nxt_rev   = r1[16];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            freq_ff  <= 16'h0;
            rev_ff   <= 1'b0;
            valid_ff <= 1'b0;
            src2_ff  <= 1'b0;
            mism_ff  <= 1'b0;
        end else begin
            freq_ff  <= nxt_freq;
            rev_ff   <= nxt_rev;
            valid_ff <= nxt_valid;
            src2_ff  <= nxt_src2;
            mism_ff  <= mismatch;
        end
    end

    // Status shows the registered outputs, so it trails selection by one edge
    always_comb begin
        status = 32'h0;
        status[freq_sel_pkg::ST_CH2_SRC]  = valid_ff && src2_ff;
        status[freq_sel_pkg::ST_CH1_SRC]  = valid_ff && !src2_ff;
        status[freq_sel_pkg::ST_REVERSE]  = rev_ff;
        status[freq_sel_pkg::ST_MISMATCH] = mism_ff;
        status[freq_sel_pkg::ST_FREQ_LSB +: 16] = freq_ff;
    end

    assign freq_cmd    = freq_ff;
    assign reverse_cmd = rev_ff;
    assign cmd_valid   = valid_ff;
endmodule : analog_freq_input_select

// file: pkg/freq_sel_pkg.sv
// Constants for the analog frequency-command selector.
// Assumes an APB slave with 32-bit data and 12-bit digitised samples.
// Summary of operation
// - Codes 0 and 10 scale the first channel to 0-10 V full scale, codes 1 and 11 to 0-5 V.
// - The analog input select code resets to 1 and only the 0-5 V and 0-10 V ranges exist.
// - Codes 10 and 11 allow reverse commands, codes 0 and 1 give forward commands only.
// - The second channel defaults to 4-20 mA current input and may be set for voltage.
// - Type 0 is current, types 1 and 2 are voltage with the switch at V, reset type is 0.
// - The enable signal makes the second channel the source and the first one invalid.
// - The enable comes from its own pin unless a terminal function select holds 4.
// - The first channel is ignored while the thermistor level differs from 9999.
// - Forward-only full-scale input on the first channel gives the gain frequency.
// - Changing the select code touches no acceleration or deceleration timing.
// - The gain frequency takes effect on write without the command being applied.
// - Reversible 0-5 V with bias at half gain reverses below 2.5 V, forward above.
// - Reversible second channel in default calibration reverses below 4 mA.
// - With reversible operation and no input the second channel gives reverse rotation; the first, with bias 0, gives zero forward.
// - Select code and input type are writable only while the visibility code is 0.
package freq_sel_pkg;
    // ====================================================================
    // Register offsets
    localparam logic [7:0] OFS_ANALOG_SEL = 8'h00;
    localparam logic [7:0] OFS_CH2_TYPE   = 8'h04;
    localparam logic [7:0] OFS_EXT_VIS    = 8'h08;
    localparam logic [7:0] OFS_THERM      = 8'h0c;
    localparam logic [7:0] OFS_TERM_FN0   = 8'h10;
    localparam logic [7:0] OFS_CH1_GFREQ  = 8'h24;
    localparam logic [7:0] OFS_CH2_GFREQ  = 8'h28;
    localparam logic [7:0] OFS_CH1_BIAS   = 8'h2c;
    localparam logic [7:0] OFS_CH1_GAIN   = 8'h30;
    localparam logic [7:0] OFS_CH2_BIAS   = 8'h34;
    localparam logic [7:0] OFS_CH2_GAIN   = 8'h38;
    localparam logic [7:0] OFS_STATUS     = 8'h3c;
    localparam int         NUM_TERM       = 5;
    // ====================================================================
    // Codes and reset values
    localparam logic [7:0]  SEL_10V       = 8'h00;
    localparam logic [7:0]  SEL_5V        = 8'h01;
    localparam logic [7:0]  SEL_10V_REV   = 8'h0a;
    localparam logic [7:0]  SEL_5V_REV    = 8'h0b;
    localparam logic [7:0]  TYPE_CURRENT  = 8'h00;
    localparam logic [7:0]  TYPE_5V       = 8'h01;
    localparam logic [7:0]  TYPE_10V      = 8'h02;
    localparam logic [7:0]  FN_CH2_ENABLE = 8'h04;
    localparam logic [15:0] THERM_OFF     = 16'h270f;
    localparam logic [7:0]  EXT_VIS_RST   = 8'h00;
    localparam logic [7:0]  TERM_FN_RST   = 8'h00;
    localparam logic [15:0] GFREQ_RST     = 16'h1770;
    localparam logic [11:0] CH1_BIAS_RST  = 12'h000;
    localparam logic [11:0] CH2_BIAS_RST  = 12'h333;
    localparam logic [11:0] GAIN_PT_RST   = 12'hfff;
    localparam logic [11:0] ADC_FULL      = 12'hfff;
    // Status bit positions
    localparam int ST_CH2_SRC  = 0;
    localparam int ST_CH1_SRC  = 1;
    localparam int ST_REVERSE  = 2;
    localparam int ST_MISMATCH = 3;
    localparam int ST_FREQ_LSB = 16;
endpackage : freq_sel_pkg

// file: tb/freq_sel_assertions.sv
// Checker for the selector's APB slave and its refusals.
// Assumes it is bound to analog_freq_input_select.
`timescale 1ns/1ns
module freq_sel_checker (
    input wire logic        clk,     // Clock
    input wire logic        arst_n,  // Reset, active low
    input wire logic        psel,    // Select
    input wire logic        penable, // Enable
    input wire logic        pwrite,  // Write
    input wire logic [7:0]  paddr,   // Address
    input wire logic [31:0] pwdata,  // Write data
    input wire logic [31:0] prdata,  // Read data
    input wire logic        pready,  // Ready
    input wire logic        pslverr  // Error
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // ====================================================================
    // Shadow of the visibility code, to know when the selects are locked
    logic [7:0] vis_ff;
    logic [7:0] nxt_vis;
    logic       setup;
    assign setup = psel && !penable;
    always_comb begin
        nxt_vis = vis_ff;
        if (psel && penable && pready && pwrite && !pslverr
            && paddr == freq_sel_pkg::OFS_EXT_VIS) begin
            nxt_vis = pwdata[7:0];
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            vis_ff <= 8'h00;
        end else begin
            vis_ff <= nxt_vis;
        end
    end
    // ====================================================================
    // Bus timing and refusals
    ready_after_setup_a: assert property (setup |=> pready)
        else $error("No ready after setup");
    ready_once_a: assert property (pready |=> !pready)
        else $error("Ready held too long");
    err_needs_ready_a: assert property (pslverr |-> pready)
        else $error("Error without ready");
    rdata_idle_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
        else $error("Read data outside a read");
    unmapped_err_a: assert property (setup && paddr > freq_sel_pkg::OFS_STATUS |=> pslverr)
        else $error("Unmapped access accepted");
    status_ro_a: assert property (setup && pwrite && paddr == freq_sel_pkg::OFS_STATUS
        |=> pslverr) else $error("Status write accepted");
    bad_code_a: assert property (setup && pwrite && paddr == 8'h00
        && pwdata[31:8] == 24'h0
        && !(pwdata[7:0] inside {8'h00, 8'h01, 8'h0a, 8'h0b}) |=> pslverr)
        else $error("Illegal select code accepted");
    bad_type_a: assert property (setup && pwrite && paddr == 8'h04
        && pwdata[31:8] == 24'h0 && pwdata[7:0] > 8'h02 |=> pslverr)
        else $error("Illegal input type accepted");
    locked_sel_a: assert property (setup && pwrite && vis_ff != 8'h00
        && (paddr == 8'h00 || paddr == 8'h04) |=> pslverr)
        else $error("Locked select written");
endmodule : freq_sel_checker
bind analog_freq_input_select freq_sel_checker freq_sel_checker_inst (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// file: tb/analog_source_model.sv
// Analog source: a knob or adjuster feeding both channels.
// Assumes the bench sets the targets; slow mode turns the knob by hand.
`timescale 1ns/1ns
module analog_source_model (
    input  wire logic        clk,        // Clock
    input  wire logic        slow,       // Ramp one code per clock
    input  wire logic [11:0] ch1_target, // First channel level
    input  wire logic [11:0] ch2_target, // Second channel level
    output logic      [11:0] ch1_sample, // First channel value
    output logic      [11:0] ch2_sample, // Second channel value
    output logic             settled     // Both at target
);
    // A hand-turned knob never jumps, so slow mode walks the code
    function automatic logic [11:0] walk(input logic [11:0] cur, input logic [11:0] tgt,
                                         input logic s);
        if (!s || cur == tgt) begin
            return tgt;
        end
        return (cur < tgt) ? cur + 12'h001 : cur - 12'h001;
    endfunction : walk
    initial begin
        ch1_sample = 12'h000;
        ch2_sample = 12'h000;
    end
    always @(posedge clk) begin
        ch1_sample <= walk(ch1_sample, ch1_target, slow);
        ch2_sample <= walk(ch2_sample, ch2_target, slow);
    end
    assign settled = (ch1_sample == ch1_target) && (ch2_sample == ch2_target);
endmodule : analog_source_model

// file: tb/analog_freq_input_select_tb.sv
// Self-checking bench for the analog frequency-command selector.
// Assumes the package, the design, the source model and the checker.
`timescale 1ns/1ns
module analog_freq_input_select_tb;
    logic        clk = 1'b0;
    logic        arst_n, psel, penable, pwrite, pready, pslverr, er;
    logic        ch2_enable_pin, volt_switch, reverse_cmd, cmd_valid, slow, settled;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [11:0] ch1_sample, ch2_sample, ch1_t, ch2_t, x, bp;
    logic [4:0]  term_pins;
    logic [15:0] freq_cmd, gf;
    logic [7:0]  codes [4];
    logic [11:0] corner [5];
    int          err_total = 0;
    int          n_checks = 0;
    analog_freq_input_select analog_freq_input_select_inst (
        .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ch1_sample(ch1_sample), .ch2_sample(ch2_sample), .ch2_enable_pin(ch2_enable_pin),
        .term_pins(term_pins), .volt_switch(volt_switch), .freq_cmd(freq_cmd),
        .reverse_cmd(reverse_cmd), .cmd_valid(cmd_valid));
    analog_source_model analog_source_model_inst (
        .clk(clk), .slow(slow), .ch1_target(ch1_t), .ch2_target(ch2_t),
        .ch1_sample(ch1_sample), .ch2_sample(ch2_sample), .settled(settled));
    always #25 clk = ~clk;
    // ====================================================================
    // Tasks
    task automatic close_out;
        $display("Checks %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 16 && pready !== 1'b1; i++) begin
            @(posedge clk);
        end
        if (pready !== 1'b1) begin
            err_total++;
            close_out();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic e);
        apb(1'b1, a, d);
        chk({32'h0, er}, {32'h0, e});
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
        apb(1'b0, a, 16'h0000);
        chk({er, rd}, {17'h0, e});
    endtask : rdchk
    task automatic set_in(input logic [11:0] a, input logic [11:0] b, input logic en,
                          input logic sw, input logic [4:0] tp);
        @(posedge clk);
        ch1_t <= a;
        ch2_t <= b;
        ch2_enable_pin <= en;
        volt_switch <= sw;
        term_pins <= tp;
    endtask : set_in
    // Waits for the source to settle, then for the pin synchronisers
    task automatic cmd_chk(input logic v, input logic [16:0] e);
        @(negedge clk);
        for (int i = 0; i < 5000 && settled !== 1'b1; i++) begin
            @(negedge clk);
        end
        if (settled !== 1'b1) begin
            err_total++;
            close_out();
        end
        repeat (4) @(negedge clk);
        if (v) begin
            chk({15'h0, cmd_valid, reverse_cmd, freq_cmd}, {15'h0, v, e});
        end else begin
            chk({32'h0, cmd_valid}, 33'h0);
        end
    endtask : cmd_chk
    function automatic logic [16:0] expect_cmd(input logic [11:0] s, input logic [11:0] b,
        input logic [11:0] g, input logic [15:0] f, input logic rev, input logic dbl);
        int xx;
        int d;
        int q;
        xx = dbl ? ((s > 12'h7ff) ? 4095 : 2 * int'(s)) : int'(s);
        d = (g > b) ? int'(g) - int'(b) : 1;
        if (xx >= int'(b)) begin
            q = (xx - int'(b)) * int'(f) / d;
            return {1'b0, (q > int'(f)) ? f : q[15:0]};
        end
        q = rev ? (int'(b) - xx) * int'(f) / d : 0;
        return {rev, q[15:0]};
    endfunction : expect_cmd
    // ====================================================================
    // Main sequence
    initial begin
        void'($urandom(32'hb1b4));
        {arst_n, psel, penable, pwrite, slow, ch2_enable_pin, volt_switch} = 7'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        ch1_t = 12'h000;
        ch2_t = 12'h000;
        term_pins = 5'h00;
        codes = '{freq_sel_pkg::SEL_10V, freq_sel_pkg::SEL_5V, freq_sel_pkg::SEL_10V_REV,
                  freq_sel_pkg::SEL_5V_REV};
        corner = '{12'h000, 12'hfff, 12'h3ff, 12'h400, 12'h333};
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        rdchk(freq_sel_pkg::OFS_ANALOG_SEL, 16'h0001);
        rdchk(freq_sel_pkg::OFS_CH2_TYPE, 16'h0000);
        rdchk(freq_sel_pkg::OFS_THERM, 16'h270f);
        apb(1'b0, 8'h40, 16'h0000);
        chk({32'h0, er}, 33'h1);
        $display("Test reset values done");
        foreach (codes[c]) begin
            bp = codes[c][3] ? 12'h7ff : 12'h000;
            gf = 16'($urandom_range(32'hffff, 32'h0100));
            wr(freq_sel_pkg::OFS_ANALOG_SEL, {8'h00, codes[c]}, 1'b0);
            wr(freq_sel_pkg::OFS_CH1_BIAS, {4'h0, bp}, 1'b0);
            wr(freq_sel_pkg::OFS_CH1_GFREQ, gf, 1'b0);
            for (int k = 0; k < 7; k++) begin
                x = (k < 5) ? corner[k] : 12'($urandom);
                slow <= (k == 6);
                set_in(x, 12'($urandom), 1'b0, 1'b0, 5'h00);
                cmd_chk(1'b1, expect_cmd(x, bp, 12'hfff, gf,
                                         codes[c][3], codes[c][0]));
            end
        end
        slow <= 1'b0;
        $display("Test first channel codes done");
        wr(freq_sel_pkg::OFS_THERM, 16'h270e, 1'b0);
        cmd_chk(1'b0, 17'h0);
        wr(freq_sel_pkg::OFS_THERM, 16'h270f, 1'b0);
        cmd_chk(1'b1, expect_cmd(x, bp, 12'hfff, gf, 1'b1, 1'b1));
        foreach (corner[k]) begin
            set_in(12'($urandom), corner[k], 1'b1, 1'b0, 5'h00);
            cmd_chk(1'b1, expect_cmd(corner[k], 12'h333, 12'hfff, 16'h1770,
                                     1'b1, 1'b0));
        end
        set_in(12'h800, 12'h800, 1'b1, 1'b1, 5'h00);
        cmd_chk(1'b0, 17'h0);
        rdchk(freq_sel_pkg::OFS_STATUS, 16'h0008);
        for (int t = 0; t < 5; t++) begin
            wr(freq_sel_pkg::OFS_TERM_FN0 + 8'(4 * t), 16'h0004, 1'b0);
            set_in(12'h100, 12'h900, 1'b1, 1'b0, 5'h00);
            cmd_chk(1'b1, expect_cmd(12'h100, bp, 12'hfff, gf, 1'b1, 1'b1));
            set_in(12'h100, 12'h900, 1'b0, 1'b0, 5'(1 << t));
            cmd_chk(1'b1, expect_cmd(12'h900, 12'h333, 12'hfff, 16'h1770, 1'b1, 1'b0));
            wr(freq_sel_pkg::OFS_TERM_FN0 + 8'(4 * t), 16'h0000, 1'b0);
        end
        $display("Test source selection done");
        for (int t = 1; t < 3; t++) begin
            wr(freq_sel_pkg::OFS_CH2_TYPE, 16'(t), 1'b0);
            wr(freq_sel_pkg::OFS_CH2_BIAS, 16'h0000, 1'b0);
            set_in(12'h100, 12'h600, 1'b1, 1'b1, 5'h00);
            cmd_chk(1'b1, expect_cmd(12'h600, 12'h000, 12'hfff, 16'h1770, 1'b1, t == 1));
            set_in(12'h100, 12'h600, 1'b1, 1'b0, 5'h00);
            cmd_chk(1'b0, 17'h0);
        end
        wr(freq_sel_pkg::OFS_CH2_TYPE, 16'h0003, 1'b1);
        $display("Test input types done");
        wr(freq_sel_pkg::OFS_EXT_VIS, 16'h0001, 1'b0);
        wr(freq_sel_pkg::OFS_ANALOG_SEL, 16'h0000, 1'b1);
        wr(freq_sel_pkg::OFS_CH2_TYPE, 16'h0000, 1'b1);
        rdchk(freq_sel_pkg::OFS_ANALOG_SEL, 16'h000b);
        wr(freq_sel_pkg::OFS_EXT_VIS, 16'h0000, 1'b0);
        wr(freq_sel_pkg::OFS_ANALOG_SEL, 16'h0005, 1'b1);
        wr(freq_sel_pkg::OFS_STATUS, 16'h0000, 1'b1);
        wr(freq_sel_pkg::OFS_CH2_TYPE, 16'h0000, 1'b0);
        $display("Test write locking done");
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        rdchk(freq_sel_pkg::OFS_ANALOG_SEL, 16'h0001);
        $display("Test second reset done");
        close_out();
    end
endmodule : analog_freq_input_select_tb
